// ### logic/adc_ctl.sv
module adc_ctl (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // register bus
    input  wire adc_ctl_pkg::axil_req_t axi_req,
    output adc_ctl_pkg::axil_rsp_t      axi_rsp,
    // analog front end
    input  wire logic [11:0]            afe_sample,
    input  wire logic                   rc_osc,
    output logic                        afe_busy,
    // core sleep and interrupt lines
    input  wire logic                   sleep,
    output logic                        irq,
    output logic                        periph_irq,
    output logic                        wake,
    output logic                        isr_req
);
    import adc_ctl_pkg::*;

    typedef struct packed {
        conv_st_t           st;
        logic [4:0]         tad_cnt;
        logic [11:0]        result;
        logic signed [15:0] err;
        logic [15:0]        upper;
        logic [15:0]        lower;
        logic [15:0]        setpt;
        logic               src_rc;
        logic [5:0]         div_sel;
        logic               done_flag;
        logic               die;
        logic               pie;
        logic               global_irq_en;
        logic [2:0]         threshold_irq_mode;
        logic               below;
        logic               above;
        logic [1:0]         sts;
        logic [1:0]         mask;
        logic               sleep_d;
        logic               aw_got;
        logic               w_got;
        logic [AW-1:0]      awaddr;
        logic [31:0]        wdata;
        logic [3:0]         wstrb;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
    } ctl_st_t;

    ctl_st_t            s_r;
    ctl_st_t            s_nxt;
    logic               tick;
    logic               run;
    logic               go;
    logic               wr_now;
    logic               done_clr;
    logic               rd_clr;
    logic [31:0]        ctrl_word;
    logic [31:0]        w;
    logic signed [15:0] err_new;
    logic               below_new;
    logic               above_new;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic thr_hit(input logic [2:0] mode,
                                     input logic       lo,
                                     input logic       hi);
        case (mode)
            TMD_BELOW:   return lo;
            TMD_ABOVE:   return hi;
            TMD_OUTSIDE: return lo | hi;
            TMD_INSIDE:  return ~(lo | hi);
            TMD_ALWAYS:  return 1'b1;
            default:     return 1'b0;
        endcase
    endfunction : thr_hit

    // the source oscillator stops in sleep, so only the rc clock advances
    assign run = (s_r.st == ST_CONV) && !(sleep && !s_r.src_rc);

    conv_clk_gen u_clk (
        .aclk    (aclk),
        .aresetn (aresetn),
        .rc_osc  (rc_osc),
        .src_rc  (s_r.src_rc),
        .div_sel (s_r.div_sel),
        .run     (run),
        .tick    (tick)
    );

    assign ctrl_word = {15'h0000, s_r.above, s_r.below, s_r.threshold_irq_mode, s_r.global_irq_en, s_r.pie,
                        s_r.die, s_r.done_flag, s_r.div_sel, s_r.src_rc,
                        s_r.st != ST_IDLE};

    assign err_new   = 16'($signed({4'h0, s_r.result}) - $signed(s_r.setpt));
    assign below_new = err_new < $signed(s_r.lower);
    assign above_new = err_new > $signed(s_r.upper);

    assign wr_now = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    assign w      = merge(ctrl_word, s_r.wdata, s_r.wstrb);

    always_comb begin
        s_nxt = s_r;
        go = 1'b0;
        done_clr = 1'b0;
        rd_clr = 1'b0;
        s_nxt.sleep_d = sleep;

        // address and data are taken in either order, then written together
        if (axi_req.awvalid && !s_r.aw_got) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !s_r.w_got) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = axi_req.wdata;
            s_nxt.wstrb = axi_req.wstrb;
        end
        if (s_r.bvalid && axi_req.bready) begin
            s_nxt.bvalid = 1'b0;
        end

        if (wr_now) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            case (s_r.awaddr)
                A_CTRL: begin
                    s_nxt.src_rc = w[CTL_SRC];
                    s_nxt.div_sel = w[CTL_DIV +: 6];
                    s_nxt.die = w[CTL_DIE];
                    s_nxt.pie = w[CTL_PIE];
                    s_nxt.global_irq_en = w[CTL_GIE];
                    s_nxt.threshold_irq_mode = w[CTL_TMD +: 3];
                    go = s_r.wstrb[0] && s_r.wdata[CTL_GO];
                    // writing one leaves the flag alone
                    done_clr = s_r.wstrb[1] && !s_r.wdata[CTL_DONE];
                end
                A_LOWER: begin
                    s_nxt.lower = 16'(merge({16'h0000, s_r.lower}, s_r.wdata, s_r.wstrb));
                end
                A_UPPER: begin
                    s_nxt.upper = 16'(merge({16'h0000, s_r.upper},
                                            s_r.wdata, s_r.wstrb));
                end
                A_SETPT: begin
                    s_nxt.setpt = 16'(merge({16'h0000, s_r.setpt}, s_r.wdata, s_r.wstrb));
                end
                A_MASK: begin
                    s_nxt.mask = s_r.wstrb[0] ? s_r.wdata[1:0] : s_r.mask;
                end
                A_ERR, A_RESULT, A_STATUS: begin
                    s_nxt.bresp = RESP_OKAY;
                end
                default: begin
                    s_nxt.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (done_clr) begin
            s_nxt.done_flag = 1'b0;
        end

        if (s_r.rvalid && axi_req.rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (axi_req.arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            s_nxt.rdata = 32'h0000_0000;
            case (axi_req.araddr)
                A_CTRL:   s_nxt.rdata = ctrl_word;
                A_LOWER:  s_nxt.rdata = {16'h0000, s_r.lower};
                A_UPPER:  s_nxt.rdata = {16'h0000, s_r.upper};
                A_SETPT:  s_nxt.rdata = {16'h0000, s_r.setpt};
                A_ERR:    s_nxt.rdata = {16'h0000, s_r.err};
                A_RESULT: s_nxt.rdata = {20'h00000, s_r.result};
                A_MASK:   s_nxt.rdata = {30'h00000000, s_r.mask};
                A_STATUS: begin
                    s_nxt.rdata = {30'h00000000, s_r.sts};
                    rd_clr = 1'b1;
                end
                default:  s_nxt.rresp = RESP_SLVERR;
            endcase
        end
        if (rd_clr) begin
            s_nxt.sts = 2'b00;
        end

        // hardware sets come last so they win over a clear in the same cycle
        case (s_r.st)
            ST_IDLE: begin
                if (go) begin
                    s_nxt.st = ST_CONV;
                    s_nxt.tad_cnt = 5'h00;
                end
            end
            ST_CONV: begin
                // a tick already in flight when sleep starts must not count
                if (tick && run) begin
                    if (s_r.tad_cnt == CONV_TADS - 5'h01) begin
                        s_nxt.result = afe_sample;
                        s_nxt.st = ST_DONE;
                    end else begin
                        s_nxt.tad_cnt = s_r.tad_cnt + 5'h01;
                    end
                end
            end
            ST_DONE: begin
                s_nxt.done_flag = 1'b1;
                s_nxt.sts[STS_DONE] = 1'b1;
                s_nxt.err = err_new;
                s_nxt.below = below_new;
                s_nxt.above = above_new;
                if (thr_hit(s_r.threshold_irq_mode, below_new, above_new)) begin
                    s_nxt.sts[STS_THR] = 1'b1;
                end
                s_nxt.st = ST_IDLE;
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.upper <= UPPER_RST;
            s_r.lower <= LOWER_RST;
            s_r.setpt <= SETPT_RST;
            s_r.div_sel <= DIV_RST;
            s_r.mask <= MASK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign axi_rsp.awready = !s_r.aw_got;
    assign axi_rsp.wready  = !s_r.w_got;
    assign axi_rsp.bvalid  = s_r.bvalid;
    assign axi_rsp.bresp   = s_r.bresp;
    assign axi_rsp.arready = !s_r.rvalid;
    assign axi_rsp.rvalid  = s_r.rvalid;
    assign axi_rsp.rdata   = s_r.rdata;
    assign axi_rsp.rresp   = s_r.rresp;

    assign afe_busy   = s_r.st == ST_CONV;
    assign irq        = |(s_r.sts & s_r.mask);
    assign periph_irq = s_r.done_flag && s_r.die;
    // waking needs the peripheral enable as well, as software is told
    assign wake       = sleep && periph_irq && s_r.pie;
    // first cycle out of sleep is left to the next instruction
    assign isr_req    = periph_irq && s_r.pie && s_r.global_irq_en && !sleep && !s_r.sleep_d;

    sequence conv_end;
        s_r.st == ST_CONV && tick && run && s_r.tad_cnt == CONV_TADS - 5'h01;
    endsequence

    sequence flag_up;
        s_r.st == ST_DONE ##1 s_r.done_flag;
    endsequence

    done_sets_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        conv_end |=> flag_up)
        else $error("done flag not set after conversion");

    flag_sticky_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_r.done_flag && !done_clr |=> s_r.done_flag)
        else $error("done flag cleared without software");

    irq_request_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_r.st == ST_DONE && s_r.die |=> periph_irq && s_r.sts[STS_DONE])
        else $error("no request after conversion");

    sleep_stall_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_r.st == ST_CONV && sleep && !s_r.src_rc |=> $stable(s_r.tad_cnt))
        else $error("conversion advanced in sleep");

    sleep_wake_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_r.st == ST_DONE && s_r.die && s_r.pie && sleep ##1 sleep |-> wake)
        else $error("no wake on completion in sleep");

    resume_first_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $fell(sleep) |-> !isr_req)
        else $error("vector taken before next instruction");

    thr_flags_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_r.st == ST_DONE |=> s_r.below == (s_r.err < $signed(s_r.lower))
            && s_r.above == (s_r.err > $signed(s_r.upper)) && s_r.done_flag)
        else $error("threshold flags wrong");

    thr_never_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_r.st == ST_DONE && s_r.threshold_irq_mode == TMD_NEVER && !s_r.sts[STS_THR] |=> !s_r.sts[STS_THR])
        else $error("threshold interrupt in never mode");

    upper_rw_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_now && s_r.awaddr == A_UPPER && s_r.wstrb[1:0] == 2'b11
            |=> s_r.upper == $past(s_r.wdata[15:0]))
        else $error("upper threshold not written");
endmodule : adc_ctl

// ### common/adc_ctl_pkg.sv
package adc_ctl_pkg;
    localparam int AW = 12;

    // register indices; the byte address is four times the index
    localparam logic [9:0] IDX_CTRL   = 10'h080;
    localparam logic [9:0] IDX_LOWER  = 10'h08c;
    localparam logic [9:0] IDX_UPPER  = 10'h08e;
    localparam logic [9:0] IDX_SETPT  = 10'h090;
    localparam logic [9:0] IDX_ERR    = 10'h091;
    localparam logic [9:0] IDX_RESULT = 10'h092;
    localparam logic [9:0] IDX_STATUS = 10'h093;
    localparam logic [9:0] IDX_MASK   = 10'h094;

    localparam logic [AW-1:0] A_CTRL   = {IDX_CTRL, 2'b00};
    localparam logic [AW-1:0] A_LOWER  = {IDX_LOWER, 2'b00};
    localparam logic [AW-1:0] A_UPPER  = {IDX_UPPER, 2'b00};
    localparam logic [AW-1:0] A_SETPT  = {IDX_SETPT, 2'b00};
    localparam logic [AW-1:0] A_ERR    = {IDX_ERR, 2'b00};
    localparam logic [AW-1:0] A_RESULT = {IDX_RESULT, 2'b00};
    localparam logic [AW-1:0] A_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [AW-1:0] A_MASK   = {IDX_MASK, 2'b00};

    // control word fields
    localparam int CTL_GO    = 0;
    localparam int CTL_SRC   = 1;
    localparam int CTL_DIV   = 2;
    localparam int CTL_DONE  = 8;
    localparam int CTL_DIE   = 9;
    localparam int CTL_PIE   = 10;
    localparam int CTL_GIE   = 11;
    localparam int CTL_TMD   = 12;
    localparam int CTL_BELOW = 15;
    localparam int CTL_ABOVE = 16;

    // status and mask fields
    localparam int STS_DONE = 0;
    localparam int STS_THR  = 1;

    // reset values
    localparam logic [15:0] UPPER_RST = 16'h0000;
    localparam logic [15:0] LOWER_RST = 16'h0000;
    localparam logic [15:0] SETPT_RST = 16'h0000;
    localparam logic [5:0]  DIV_RST   = 6'h02;
    localparam logic [1:0]  MASK_RST  = 2'h0;

    // divider selection codes and their ratios
    localparam logic [5:0] SEL_DIV6   = 6'h02;
    localparam logic [5:0] SEL_DIV8   = 6'h03;
    localparam logic [5:0] SEL_DIV16  = 6'h04;
    localparam logic [5:0] SEL_DIV128 = 6'h3f;
    localparam logic [7:0] DIV6       = 8'h06;
    localparam logic [7:0] DIV8       = 8'h08;
    localparam logic [7:0] DIV16      = 8'h10;
    localparam logic [7:0] DIV128     = 8'h80;

    // conversion bit periods per conversion
    localparam logic [4:0] CONV_TADS = 5'h0e;

    // threshold interrupt modes
    localparam logic [2:0] TMD_NEVER   = 3'h0;
    localparam logic [2:0] TMD_BELOW   = 3'h1;
    localparam logic [2:0] TMD_ABOVE   = 3'h2;
    localparam logic [2:0] TMD_OUTSIDE = 3'h3;
    localparam logic [2:0] TMD_INSIDE  = 3'h4;
    localparam logic [2:0] TMD_ALWAYS  = 3'h5;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_DONE = 3'b100
    } conv_st_t;

    typedef struct packed {
        logic          awvalid;
        logic [AW-1:0] awaddr;
        logic          wvalid;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          bready;
        logic          arvalid;
        logic [AW-1:0] araddr;
        logic          rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;
endpackage : adc_ctl_pkg

// ### logic/conv_clk_gen.sv
module conv_clk_gen (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // dedicated oscillator pin
    input  wire logic       rc_osc,
    // source and divider choice
    input  wire logic       src_rc,
    input  wire logic [5:0] div_sel,
    input  wire logic       run,
    // conversion clock, one pulse per bit period
    output logic            tick
);
    import adc_ctl_pkg::*;

    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       s3;
        logic [7:0] cnt;
        logic       tick;
    } gen_st_t;

    gen_st_t    s_r;
    gen_st_t    s_nxt;
    logic [7:0] div_n;

    function automatic logic [7:0] div_count(input logic [5:0] sel);
        case (sel)
            SEL_DIV6:   return DIV6;
            SEL_DIV8:   return DIV8;
            SEL_DIV16:  return DIV16;
            SEL_DIV128: return DIV128;
            // unlisted codes fall back to the slowest, always legal ratio
            default:    return DIV128;
        endcase
    endfunction : div_count

    assign div_n = div_count(div_sel);
    assign tick  = s_r.tick;

    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = rc_osc;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        s_nxt.tick = 1'b0;
        if (!run) begin
            s_nxt.cnt = 8'h00;
        end else if (src_rc) begin
            s_nxt.cnt = 8'h00;
            s_nxt.tick = s_r.s2 & ~s_r.s3;
        end else if (s_r.cnt >= div_n - 8'h01) begin
            // >= so a smaller ratio written mid-count cannot run away
            s_nxt.cnt = 8'h00;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    sequence div6_run;
        run && !src_rc && div_sel == SEL_DIV6;
    endsequence

    div6_period_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        div6_run ##0 tick ##1 div6_run [*6] |-> tick)
        else $error("divide-by-6 tick period wrong");
endmodule : conv_clk_gen

// ### sim/afe_model.sv
module afe_model (
    // conversion handshake
    input  wire logic        afe_busy,
    input  wire logic        rc_run,
    input  wire logic [11:0] sample_val,
    // front end outputs
    output logic [11:0]      afe_sample,
    output logic             rc_osc
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus shows the inverse, so a stale capture never matches
    assign afe_sample = afe_busy ? sample_val : ~sample_val;

    // period unrelated to aclk; stands still when no conversion needs it
    initial begin
        rc_osc = 1'b0;
        forever begin
            #37;
            if (rc_run && afe_busy) begin
                rc_osc = ~rc_osc;
            end else begin
                rc_osc = 1'b0;
            end
        end
    end
endmodule : afe_model

// ### sim/adc_ctl_test.sv
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end

module adc_ctl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_ctl_pkg::*;

    logic        aclk, aresetn, sleep, rc_run, afe_busy, rc_osc;
    logic        irq, periph_irq, wake, isr_req;
    axil_req_t   axi_req;
    axil_rsp_t   axi_rsp;
    logic [11:0] sample_val, afe_sample;
    logic [31:0] rdat;
    logic [1:0]  resp;
    int          n_errors, n_compared, n;
    logic [5:0]  sel [4] = '{SEL_DIV6, SEL_DIV8, SEL_DIV16, SEL_DIV128};
    logic [7:0]  rat [4] = '{DIV6, DIV8, DIV16, DIV128};
    // threshold event per mode 0..5 for an error below the lower threshold
    logic [5:0]  thr_exp = 6'b101010;

    adc_ctl dut (.aclk, .aresetn, .axi_req, .axi_rsp, .afe_sample, .rc_osc,
                 .afe_busy, .sleep, .irq, .periph_irq, .wake, .isr_req);
    afe_model afe (.afe_busy, .rc_run, .sample_val, .afe_sample, .rc_osc);

    task automatic end_sim;
        if (n_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // handshakes judged at the negedge, where the edge's inputs are settled
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_hs, w_hs, b_hs;
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr  <= a;
        axi_req.wvalid  <= 1'b1;
        axi_req.wdata   <= d;
        axi_req.wstrb   <= s;
        b_hs = 1'b0;
        while (!b_hs) begin
            @(negedge aclk);
            aw_hs = axi_req.awvalid && axi_rsp.awready;
            w_hs = axi_req.wvalid && axi_rsp.wready;
            b_hs = axi_rsp.bvalid;
            resp = axi_rsp.bresp;
            @(posedge aclk);
            if (aw_hs) axi_req.awvalid <= 1'b0;
            if (w_hs) axi_req.wvalid <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [11:0] a);
        logic ar_hs, r_hs;
        axi_req.arvalid <= 1'b1;
        axi_req.araddr  <= a;
        r_hs = 1'b0;
        while (!r_hs) begin
            @(negedge aclk);
            ar_hs = axi_req.arvalid && axi_rsp.arready;
            r_hs = axi_rsp.rvalid;
            rdat = axi_rsp.rdata;
            resp = axi_rsp.rresp;
            @(posedge aclk);
            if (ar_hs) axi_req.arvalid <= 1'b0;
        end
    endtask : rd

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        rd(a);
        `CHK(rdat & m, e)
    endtask : rd_chk

    // counts remaining busy cycles; returns on a rising edge
    task automatic wt(output int c);
        c = 0;
        @(negedge aclk);
        while (afe_busy === 1'b1 && c < 5000) begin
            c++;
            @(negedge aclk);
        end
        `CHK(c < 5000, 1'b1)
        // one more edge so flags set in the done cycle have landed
        @(negedge aclk);
        @(posedge aclk);
    endtask : wt

    // go bit set, done bit written 1 so the flag is left alone
    function automatic logic [31:0] cw(logic src, logic [5:0] div, logic [2:0] en,
                                       logic [2:0] threshold_irq_mode);
        return {17'h0, threshold_irq_mode, en, 1'b1, div, src, 1'b1};
    endfunction : cw

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial begin
        #200us;
        n_errors++;
        end_sim();
    end

    initial begin
        aresetn = 1'b0;
        axi_req = '0;
        // response readies stay high, so back-to-back calls never toggle them
        axi_req.bready = 1'b1;
        axi_req.rready = 1'b1;
        sleep = 1'b0;
        rc_run = 1'b0;
        sample_val = 12'h042;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(A_UPPER, 32'h0, 32'hffff);
        wr(A_UPPER, 32'h0000_beef, 4'h3);
        `CHK(resp, RESP_OKAY)
        rd_chk(A_UPPER, 32'hbeef, 32'hffff);
        wr(A_UPPER, 32'h0000_1200, 4'h2);
        rd_chk(A_UPPER, 32'h12ef, 32'hffff);
        rd(12'hffc);
        `CHK(resp, RESP_SLVERR)
        wr(12'hffc, 32'h0, 4'hf);
        `CHK(resp, RESP_SLVERR)
        wr(A_LOWER, 32'd100, 4'hf);
        wr(A_UPPER, 32'd200, 4'hf);
        wr(A_SETPT, 32'h10, 4'hf);
        wr(A_MASK, 32'h2, 4'hf);
        for (int i = 0; i < 4; i++) begin
            wr(A_CTRL, cw(1'b0, sel[i], 3'b000, TMD_NEVER), 4'hf);
            wt(n);
            `CHK(n >= 14 * rat[i] - 4 && n <= 15 * rat[i] + 4, 1'b1)
            `CHK(periph_irq, 1'b0)
        end
        rd_chk(A_CTRL, 32'h0000_8100, 32'h0001_8100);
        rd_chk(A_ERR, 32'h32, 32'hffff);
        rd(A_STATUS);
        wr(A_CTRL, 32'h100, 4'h2);
        rd_chk(A_CTRL, 32'h100, 32'h100);
        wr(A_CTRL, 32'h0, 4'h2);
        rd_chk(A_CTRL, 32'h0, 32'h100);
        // error 0x32 sits below the lower threshold: modes 1, 3 and 5 fire
        for (int m = 0; m < 6; m++) begin
            wr(A_CTRL, cw(1'b0, SEL_DIV6, 3'b000, 3'(m)), 4'hf);
            wt(n);
            `CHK(irq, thr_exp[m])
            rd_chk(A_STATUS, {30'h0, thr_exp[m], 1'b1}, 32'h3);
            `CHK(irq, 1'b0)
        end
        sample_val <= 12'h100;
        wr(A_CTRL, cw(1'b0, SEL_DIV6, 3'b000, TMD_NEVER), 4'hf);
        wt(n);
        rd_chk(A_CTRL, 32'h1_0000, 32'h1_8000);
        sample_val <= 12'h0a0;
        wr(A_CTRL, cw(1'b0, SEL_DIV6, 3'b000, TMD_NEVER), 4'hf);
        wt(n);
        rd_chk(A_CTRL, 32'h0, 32'h1_8000);
        wr(A_CTRL, 32'h0, 4'h2);
        wr(A_CTRL, cw(1'b0, SEL_DIV6, 3'b001, TMD_NEVER), 4'hf);
        wt(n);
        `CHK(periph_irq, 1'b1)
        // system-derived clock must freeze while asleep
        wr(A_CTRL, cw(1'b0, SEL_DIV6, 3'b000, TMD_NEVER), 4'hf);
        sleep <= 1'b1;
        repeat (200) @(posedge aclk);
        `CHK(afe_busy, 1'b1)
        sleep <= 1'b0;
        wt(n);
        `CHK(n < 100, 1'b1)
        wr(A_CTRL, 32'h0, 4'h2);
        rc_run <= 1'b1;
        wr(A_CTRL, cw(1'b1, SEL_DIV6, 3'b111, TMD_NEVER), 4'hf);
        sleep <= 1'b1;
        wt(n);
        `CHK(afe_busy, 1'b0)
        `CHK(wake, 1'b1)
        `CHK(isr_req, 1'b0)
        sleep <= 1'b0;
        @(negedge aclk);
        `CHK(isr_req, 1'b0)
        @(negedge aclk);
        `CHK(isr_req, 1'b1)
        end_sim();
    end
endmodule : adc_ctl_test
